// *** core/reset_standby_pkg.sv ***
`default_nettype none
package reset_standby_pkg;
    localparam int reset_min_clocks = 4;
    localparam int halt_status_clocks = 1;
    localparam logic [15:0] pc_reset_value = 16'h0000;
    localparam logic [15:0] pfp_reset_value = 16'h0000;
    localparam logic [15:0] ps_reset_value = 16'hFFFF;
    localparam logic [15:0] ss_reset_value = 16'h0000;
    localparam logic [15:0] ds0_reset_value = 16'h0000;
    localparam logic [15:0] ds1_reset_value = 16'h0000;
    localparam logic [15:0] psw_reset_value = 16'hF002;
    localparam int psw_ie_bit = 9;
    localparam logic [19:0] fetch_start_address = 20'hFFFF0;
    localparam logic [3:0] bs_halt_code = 4'h3;
    localparam logic [3:0] bs_idle_code = 4'hF;
    localparam int tbi_width = 23;
    localparam int tbo_width = 43;
    typedef enum logic [1:0] {
        mode_normal = 2'b00,
        mode_standby_test = 2'b01,
        mode_unit_test = 2'b11
    } test_mode_t;
    typedef enum logic [2:0] {
        st_reset = 3'b000,
        st_run = 3'b001,
        st_halt_code = 3'b011,
        st_standby = 3'b010,
        st_hold = 3'b110,
        st_wake_int = 3'b111,
        st_wake_skip = 3'b101
    } seq_state_t;
endpackage : reset_standby_pkg
`default_nettype wire

// *** core/reset_filter.sv ***
`default_nettype none
// counts consecutive high reset samples; asserts once the minimum is reached
module reset_filter #(
    parameter int min_clocks = reset_standby_pkg::reset_min_clocks
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic reset_in,
    output logic reset_active
);
    logic [3:0] count_reg;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count_reg <= 4'h0;
        end else if (!reset_in) begin
            count_reg <= 4'h0;
        end else if (count_reg < 4'(min_clocks)) begin
            count_reg <= count_reg + 4'h1;
        end
    end
    always_comb begin
        reset_active = reset_in && (count_reg >= 4'(min_clocks - 1));
    end
endmodule : reset_filter
`default_nettype wire

// *** core/reset_standby_control.sv ***
`default_nettype none
// Behaviour
// - with interrupts disabled a maskable request ends standby and resumes after the halt.
// - reset during standby, once held four clocks, leaves standby and runs a normal reset.
// - reset held high four clocks or more forces every bus output but data out to its reset state while high.
// - in reset, address, byte enable, lock and status go high, hold acknowledge low, test out off.
// - reset loads counter, prefetch, segments and the status word with their fixed values.
// - after reset falls, prefetch starts at the segment FFFFH offset 0000H address.
// - mode follows isolate and test select: normal, standby test or unit test.
// - in normal mode test inputs are ignored and test outputs float.
// - isolate high ignores the reset, interrupt, nmi and hold inputs.
// - unit test takes test inputs in place of functional ones and mirrors outputs on test out.
// - standby test ignores test inputs and floats test outputs.
// - with interrupts enabled a request ends standby and starts the interrupt routine.
// - entering standby shows the halt code one clock, then address, byte enable, status high.
// - a hold request together with an interrupt in standby is granted first.
module reset_standby_control #(
    parameter int tbi_w = reset_standby_pkg::tbi_width,
    parameter int tbo_w = reset_standby_pkg::tbo_width
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic reset_in,
    input wire logic int_request,
    input wire logic nmi_request,
    input wire logic hold_request,
    input wire logic halt_execute,
    input wire logic ack_bus_cycle,
    input wire logic hold_done,
    input wire logic isolate_select,
    input wire logic test_select,
    input wire logic [tbi_w-1:0] test_bus_in,
    input wire logic [19:0] core_address,
    input wire logic core_upper_byte_enable_n,
    input wire logic core_bus_lock_n,
    input wire logic [3:0] core_bus_status,
    input wire logic [15:0] core_data_out,
    input wire logic psw_write,
    input wire logic [15:0] psw_write_data,
    output logic [19:0] address_out,
    output logic upper_byte_enable_n,
    output logic bus_lock_n,
    output logic [3:0] bus_status,
    output logic hold_acknowledge,
    output logic [15:0] data_out,
    output logic [tbo_w-1:0] test_bus_out,
    output logic [tbo_w-1:0] test_bus_out_en,
    output logic [1:0] mode,
    output logic in_reset,
    output logic in_standby,
    output logic start_interrupt,
    output logic resume_after_halt,
    output logic fetch_start,
    output logic [19:0] fetch_address,
    output logic [15:0] program_counter,
    output logic [15:0] prefetch_pointer,
    output logic [15:0] program_segment,
    output logic [15:0] stack_segment,
    output logic [15:0] data_segment_zero,
    output logic [15:0] data_segment_one,
    output logic [15:0] program_status_word,
    output logic [3:0] func_status_in,
    output logic int_request_eff,
    output logic hold_request_eff
);
    localparam int mirror_w = 20 + 1 + 1 + 4 + 16;

    reset_standby_pkg::seq_state_t state_reg, state_next;
    logic reset_active;
    logic interrupt_enable_flag;
    logic int_eff, nmi_eff, hold_eff, reset_eff;
    logic nmi_prev_reg;
    logic nmi_rise;
    logic [mirror_w-1:0] mirror_bits;
    logic [19:0] address_next;
    logic [3:0] status_next;

    reset_filter #(
        .min_clocks(reset_standby_pkg::reset_min_clocks)
    ) u_reset_filter (
        .clk(clk),
        .resetn(resetn),
        .reset_in(reset_eff),
        .reset_active(reset_active)
    );

    // isolate alone decides test entry; test select only picks which test
    // mode select
    always_comb begin
        if (!isolate_select) begin
            mode = reset_standby_pkg::mode_normal;
        end else if (test_select) begin
            mode = reset_standby_pkg::mode_unit_test;
        end else begin
            mode = reset_standby_pkg::mode_standby_test;
        end
    end

    always_comb begin
        if (mode == reset_standby_pkg::mode_unit_test) begin
            reset_eff = test_bus_in[0];
            int_eff = test_bus_in[1];
            nmi_eff = test_bus_in[2];
            hold_eff = test_bus_in[3];
        end else if (isolate_select) begin
            reset_eff = 1'b0;
            int_eff = 1'b0;
            nmi_eff = 1'b0;
            hold_eff = 1'b0;
        end else begin
            reset_eff = reset_in;
            int_eff = int_request;
            nmi_eff = nmi_request;
            hold_eff = hold_request;
        end
        func_status_in = {hold_eff, nmi_eff, int_eff, reset_eff};
        int_request_eff = int_eff;
        hold_request_eff = hold_eff;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            nmi_prev_reg <= 1'b0;
        end else begin
            nmi_prev_reg <= nmi_eff;
        end
    end
    // only the rising edge of nmi wakes, so a level held high cannot wake twice
    assign nmi_rise = nmi_eff && !nmi_prev_reg;
    assign interrupt_enable_flag = program_status_word[reset_standby_pkg::psw_ie_bit];

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            reset_standby_pkg::st_reset: begin
                if (!reset_active) state_next = reset_standby_pkg::st_run;
            end
            reset_standby_pkg::st_run: begin
                if (halt_execute) state_next = reset_standby_pkg::st_halt_code;
            end
            reset_standby_pkg::st_halt_code: begin
                state_next = reset_standby_pkg::st_standby;
            end
            reset_standby_pkg::st_standby: begin
                if (hold_eff) begin
                    state_next = reset_standby_pkg::st_hold;
                end else if (nmi_rise || (int_eff && interrupt_enable_flag)) begin
                    state_next = reset_standby_pkg::st_wake_int;
                end else if (int_eff) begin
                    state_next = reset_standby_pkg::st_wake_skip;
                end
            end
            // back to standby with no second halt code; the idle status is shown again
            reset_standby_pkg::st_hold: begin
                if (hold_done || !hold_eff) state_next = reset_standby_pkg::st_standby;
            end
            // request relies on held level until ack cycle
            reset_standby_pkg::st_wake_int: begin
                if (ack_bus_cycle) state_next = reset_standby_pkg::st_run;
            end
            reset_standby_pkg::st_wake_skip: begin
                state_next = reset_standby_pkg::st_run;
            end
            default: state_next = reset_standby_pkg::st_reset;
        endcase
        if (reset_active) state_next = reset_standby_pkg::st_reset;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= reset_standby_pkg::st_reset;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            program_counter <= reset_standby_pkg::pc_reset_value;
            prefetch_pointer <= reset_standby_pkg::pfp_reset_value;
            program_segment <= reset_standby_pkg::ps_reset_value;
            stack_segment <= reset_standby_pkg::ss_reset_value;
            data_segment_zero <= reset_standby_pkg::ds0_reset_value;
            data_segment_one <= reset_standby_pkg::ds1_reset_value;
            program_status_word <= reset_standby_pkg::psw_reset_value;
        end else if (reset_active) begin
            program_counter <= reset_standby_pkg::pc_reset_value;
            prefetch_pointer <= reset_standby_pkg::pfp_reset_value;
            program_segment <= reset_standby_pkg::ps_reset_value;
            stack_segment <= reset_standby_pkg::ss_reset_value;
            data_segment_zero <= reset_standby_pkg::ds0_reset_value;
            data_segment_one <= reset_standby_pkg::ds1_reset_value;
            program_status_word <= reset_standby_pkg::psw_reset_value;
        end else if (psw_write) begin
            program_status_word <= psw_write_data;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fetch_start <= 1'b0;
            fetch_address <= reset_standby_pkg::fetch_start_address;
        end else begin
            // leaving the reset state covers the pin reset and the async reset alike
            fetch_start <= state_reg == reset_standby_pkg::st_reset
                && state_next != reset_standby_pkg::st_reset;
            fetch_address <= reset_standby_pkg::fetch_start_address;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            start_interrupt <= 1'b0;
            resume_after_halt <= 1'b0;
        end else begin
            start_interrupt <= state_reg == reset_standby_pkg::st_standby
                && state_next == reset_standby_pkg::st_wake_int;
            resume_after_halt <= state_next == reset_standby_pkg::st_wake_skip;
        end
    end

    always_comb begin
        address_next = core_address;
        status_next = core_bus_status;
        if (state_next == reset_standby_pkg::st_reset) begin
            address_next = '1;
            status_next = reset_standby_pkg::bs_idle_code;
        end else if (state_next == reset_standby_pkg::st_halt_code) begin
            status_next = reset_standby_pkg::bs_halt_code;
        end else if (state_next == reset_standby_pkg::st_standby) begin
            address_next = '1;
            status_next = reset_standby_pkg::bs_idle_code;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            address_out <= '1;
            upper_byte_enable_n <= 1'b1;
            bus_lock_n <= 1'b1;
            bus_status <= reset_standby_pkg::bs_idle_code;
            hold_acknowledge <= 1'b0;
            data_out <= 16'h0000;
        end else begin
            address_out <= address_next;
            bus_status <= status_next;
            data_out <= core_data_out;
            hold_acknowledge <= state_next == reset_standby_pkg::st_hold;
            if (state_next == reset_standby_pkg::st_reset) begin
                upper_byte_enable_n <= 1'b1;
                bus_lock_n <= 1'b1;
            end else if (state_next == reset_standby_pkg::st_standby) begin
                upper_byte_enable_n <= 1'b1;
                bus_lock_n <= core_bus_lock_n;
            end else begin
                upper_byte_enable_n <= core_upper_byte_enable_n;
                bus_lock_n <= core_bus_lock_n;
            end
        end
    end

    assign mirror_bits = {data_out, bus_status, bus_lock_n, upper_byte_enable_n, address_out};

    // the mirror lags the pins by one clock, which a tester must allow for
    // mirror outputs on test bus
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            test_bus_out <= '0;
            test_bus_out_en <= '0;
        end else begin
            test_bus_out <= tbo_w'({hold_acknowledge, mirror_bits});
            if (mode == reset_standby_pkg::mode_unit_test && !reset_active) begin
                test_bus_out_en <= '1;
            end else begin
                test_bus_out_en <= '0;
            end
        end
    end

    assign in_reset = state_reg == reset_standby_pkg::st_reset;
    // a granted hold still counts as standby, since the core stays halted
    assign in_standby = state_reg == reset_standby_pkg::st_standby
        || state_reg == reset_standby_pkg::st_hold;
endmodule : reset_standby_control
`default_nettype wire

// *** testbench/reset_standby_control_properties.sv ***
`default_nettype none
module reset_standby_checker #(
    parameter int tbi_w = 23,
    parameter int tbo_w = 43
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic reset_in,
    input wire logic halt_execute,
    input wire logic isolate_select,
    input wire logic test_select,
    input wire logic [tbi_w-1:0] test_bus_in,
    input wire logic [19:0] address_out,
    input wire logic upper_byte_enable_n,
    input wire logic [3:0] bus_status,
    input wire logic hold_acknowledge,
    input wire logic [tbo_w-1:0] test_bus_out_en,
    input wire logic [1:0] mode,
    input wire logic in_reset,
    input wire logic in_standby,
    input wire logic start_interrupt,
    input wire logic resume_after_halt,
    input wire logic fetch_start,
    input wire logic [19:0] fetch_address,
    input wire logic [15:0] program_segment,
    input wire logic [15:0] program_status_word,
    input wire logic [3:0] func_status_in,
    input wire logic int_request_eff,
    input wire logic hold_request_eff
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    // only a lone request is judged; hold and reset have their own precedence
    wire logic lone_int = in_standby && !hold_acknowledge && int_request_eff
        && !hold_request_eff && !reset_in;
    a_mode_table: assert property (mode == {isolate_select & test_select, isolate_select})
        else $error("mode does not follow select pins");
    a_test_out_off: assert property (mode != 2'b11 |=> test_bus_out_en == '0)
        else $error("test outputs driven outside unit test");
    a_isolate_ignore: assert property (isolate_select && !test_select |->
        func_status_in == 4'h0 && !int_request_eff && !hold_request_eff)
        else $error("functional input seen while isolated");
    a_unit_inputs: assert property (mode == 2'b11 |-> func_status_in == test_bus_in[3:0])
        else $error("unit test inputs not substituted");
    a_halt_code: assert property (halt_execute && !in_standby && !in_reset && !reset_in
        && !int_request_eff && !hold_request_eff |=> bus_status == 4'h3 ##1
        (bus_status == 4'hF && address_out == '1 && upper_byte_enable_n))
        else $error("halt status sequence wrong");
    a_reset_wait: assert property ($rose(reset_in) && !in_reset |-> !in_reset [*4])
        else $error("reset acted too early");
    a_reset_enter: assert property ((reset_in && !isolate_select) [*4] |=> in_reset)
        else $error("reset not entered after four samples");
    a_reset_pins: assert property (in_reset && $past(in_reset) |-> address_out == '1
        && upper_byte_enable_n && bus_status == 4'hF && !hold_acknowledge && test_bus_out_en == '0)
        else $error("pins not at reset levels");
    a_reset_regs: assert property (in_reset && $past(in_reset) |->
        program_segment == 16'hFFFF && program_status_word == 16'hF002)
        else $error("registers not at reset values");
    a_wake_no_ie: assert property (lone_int && !program_status_word[9] |=>
        resume_after_halt && !in_standby && !start_interrupt)
        else $error("disabled wake did not resume");
    a_wake_ie: assert property (lone_int && program_status_word[9] |->
        ##[1:2] start_interrupt)
        else $error("enabled wake did not start interrupt");
    a_hold_first: assert property (in_standby && hold_request_eff |=>
        !start_interrupt && !resume_after_halt)
        else $error("wake taken before hold");
    a_fetch_start: assert property ($fell(in_reset) |-> ##[0:1]
        (fetch_start && fetch_address == 20'hFFFF0))
        else $error("fetch start missing or wrong address");
endmodule : reset_standby_checker
`default_nettype wire

// *** testbench/sys_partner.sv ***
`default_nettype none
module sys_partner (
    input wire logic clk,
    input wire logic wake_cmd,
    input wire logic reset_cmd,
    input wire logic ack_bus_cycle,
    input wire logic resume_after_halt,
    output logic int_request,
    output logic reset_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] rst_cnt = 3'h0;
    logic int_level = 1'b0;
    assign int_request = int_level;
    assign reset_in = rst_cnt != 3'h0;
    always @(posedge clk) begin
        if (wake_cmd) begin
            int_level <= 1'b1;
        end else if (ack_bus_cycle || resume_after_halt) begin
            int_level <= 1'b0;
        end
    end
    always @(posedge clk) begin
        if (reset_cmd) begin
            rst_cnt <= 3'h6;
        end else if (rst_cnt != 3'h0) begin
            rst_cnt <= rst_cnt - 3'h1;
        end
    end
endmodule : sys_partner
`default_nettype wire

// *** testbench/tb_reset_standby_control.sv ***
`default_nettype none
module tb_reset_standby_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, resetn = 1'b0, wake_cmd = 1'b0, reset_cmd = 1'b0, nmi_request = 1'b0;
    logic hold_request = 1'b0, halt_execute = 1'b0, ack_bus_cycle = 1'b0, hold_done = 1'b0;
    logic isolate_select = 1'b0, test_select = 1'b0, psw_write = 1'b0;
    logic core_upper_byte_enable_n = 1'b0, core_bus_lock_n = 1'b1;
    logic [22:0] test_bus_in = 23'h000000;
    logic [19:0] core_address = 20'h12345, address_out, fetch_address;
    logic [3:0] core_bus_status = 4'h8, bus_status, func_status_in;
    logic [15:0] core_data_out = 16'hBEEF, psw_write_data = 16'h0000, data_out;
    logic [15:0] program_counter, prefetch_pointer, program_segment, stack_segment;
    logic [15:0] data_segment_zero, data_segment_one, program_status_word;
    logic [42:0] test_bus_out, test_bus_out_en;
    logic [1:0] mode;
    logic reset_in, int_request, upper_byte_enable_n, bus_lock_n, hold_acknowledge, in_reset;
    logic in_standby, start_interrupt, resume_after_halt, fetch_start;
    logic int_request_eff, hold_request_eff;
    int failures = 0, checks = 0;
    always #5 clk = ~clk;
    reset_standby_control uut (.clk, .resetn, .reset_in, .int_request, .nmi_request,
        .hold_request, .halt_execute, .ack_bus_cycle, .hold_done, .isolate_select, .test_select,
        .test_bus_in, .core_address, .core_upper_byte_enable_n, .core_bus_lock_n,
        .core_bus_status, .core_data_out, .psw_write, .psw_write_data, .address_out,
        .upper_byte_enable_n, .bus_lock_n, .bus_status, .hold_acknowledge, .data_out,
        .test_bus_out, .test_bus_out_en, .mode, .in_reset, .in_standby, .start_interrupt,
        .resume_after_halt, .fetch_start, .fetch_address, .program_counter, .prefetch_pointer,
        .program_segment, .stack_segment, .data_segment_zero, .data_segment_one,
        .program_status_word, .func_status_in, .int_request_eff, .hold_request_eff);
    sys_partner partner (.clk, .wake_cmd, .reset_cmd, .ack_bus_cycle, .resume_after_halt,
        .int_request, .reset_in);
    task automatic check(input string name, input logic [79:0] seen, input logic [79:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask : step
    task automatic pulse_cmd(ref logic sig);
        sig = 1'b1;
        step(1);
        sig = 1'b0;
    endtask : pulse_cmd
    task automatic halt_enter;
        pulse_cmd(halt_execute);
        check("halt_code", bus_status, 4'h3);
        step(1);
        check("standby", {in_standby, address_out, upper_byte_enable_n, bus_status},
            26'h3FFFFFF);
    endtask : halt_enter
    task automatic print_verdict;
        if (failures == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict
    initial begin
        #20000;
        failures++;
        print_verdict();
    end
    initial begin
        step(3);
        check("pins", {address_out, upper_byte_enable_n, bus_lock_n,
            bus_status, hold_acknowledge, test_bus_out_en}, {20'hFFFFF, 6'h3F, 44'h0});
        check("regs", {program_counter, prefetch_pointer, program_segment, stack_segment},
            64'hFFFF0000);
        check("psw", {program_status_word, data_segment_zero, data_segment_one},
            48'hF00200000000);
        resetn = 1'b1;
        step(4);
        // long reset pulse while running: must wait four samples
        pulse_cmd(reset_cmd);
        step(3);
        check("early", {in_reset, address_out}, 21'h012345);
        step(1);
        check("entered", {in_reset, address_out, bus_status}, 25'h1FFFFFF);
        for (int i = 0; i < 12 && fetch_start !== 1'b1; i++) step(1);
        check("fetch", {fetch_start, fetch_address}, 21'h1FFFF0);
        core_address = 20'h2ABCD;
        step(2);
        for (int m = 0; m < 4; m++) begin
            {isolate_select, test_select} = 2'(m);
            hold_request = 1'b1;
            test_bus_in = 23'h000002;
            #1;
            check("mode", mode, {m[1] & m[0], m[1]});
            check("func_in", func_status_in, m[1] ? {2'b00, m[0], 1'b0} : 4'h8);
            step(1);
            hold_request = 1'b0;
            test_bus_in = 23'h000000;
            step(1);
            check("tbo_en", test_bus_out_en, (m == 3) ? {43{1'b1}} : 43'h0);
            if (m == 3) check("tbo", test_bus_out, {1'b0, core_data_out, core_bus_status,
                core_bus_lock_n, core_upper_byte_enable_n, core_address});
        end
        isolate_select = 1'b0;
        step(2);
        // wake with interrupts disabled resumes without servicing
        halt_enter();
        pulse_cmd(wake_cmd);
        for (int i = 0; i < 8 && resume_after_halt !== 1'b1; i++) step(1);
        check("resume", {resume_after_halt, in_standby, start_interrupt}, 3'b100);
        step(2);
        psw_write_data = 16'hF202;
        pulse_cmd(psw_write);
        step(1);
        halt_enter();
        pulse_cmd(wake_cmd);
        for (int i = 0; i < 8 && start_interrupt !== 1'b1; i++) step(1);
        check("int_start", {start_interrupt, resume_after_halt}, 2'b10);
        pulse_cmd(ack_bus_cycle);
        step(2);
        // hold arriving one clock before the interrupt request: hold goes first
        halt_enter();
        hold_request = 1'b1;
        pulse_cmd(wake_cmd);
        step(4);
        check("hold", {hold_acknowledge, start_interrupt}, 2'b10);
        hold_request = 1'b0;
        pulse_cmd(hold_done);
        for (int i = 0; i < 10 && start_interrupt !== 1'b1; i++) step(1);
        check("late_int", start_interrupt, 1'b1);
        pulse_cmd(ack_bus_cycle);
        step(2);
        // rising nmi edge wakes straight into the interrupt routine
        halt_enter();
        nmi_request = 1'b1;
        step(1);
        check("nmi_wake", {start_interrupt, in_standby}, 2'b10);
        nmi_request = 1'b0;
        pulse_cmd(ack_bus_cycle);
        step(2);
        halt_enter();
        pulse_cmd(reset_cmd);
        for (int i = 0; i < 10 && in_reset !== 1'b1; i++) step(1);
        check("standby_reset", {in_reset, in_standby, program_status_word}, 18'h2F002);
        for (int i = 0; i < 12 && fetch_start !== 1'b1; i++) step(1);
        check("refetch", {fetch_start, fetch_address}, 21'h1FFFF0);
        step(2);
        print_verdict();
    end
endmodule : tb_reset_standby_control
bind reset_standby_control reset_standby_checker #(.tbi_w(tbi_w), .tbo_w(tbo_w)) chk (.clk,
    .resetn, .reset_in, .halt_execute, .isolate_select, .test_select, .test_bus_in,
    .address_out, .upper_byte_enable_n, .bus_status, .hold_acknowledge, .test_bus_out_en,
    .mode, .in_reset, .in_standby, .start_interrupt, .resume_after_halt, .fetch_start,
    .fetch_address, .program_segment, .program_status_word, .func_status_in,
    .int_request_eff, .hold_request_eff);
`default_nettype wire
